// File: hdl/data_fax_auto_answer.sv
/*
 Data/fax auto-answer controller: answers a call, tries data first,
 falls back to fax after the handshake window, and reports result codes
 and carrier detect to the host.
 Assumes the command parser, data pump and ring detector run on clk_sys
 and hand over decoded events as one-cycle pulses.
*/
// Function
// (RQ1) Enable auto-answer on command, store nonvolatile
// (RQ2) Host enables only while fax class active
// (RQ3) Host switches port rate before call arrives
// (RQ4) Try data first, fall back to fax
// (RQ5) Handshake timeout register, 0-255 s, default 06
// (RQ6) No data signal in window: fax, class 1
// (RQ7) Report ring; manual answer goes off-hook
// (RQ8) Nonzero ring count answers without host
// (RQ9) DATA code only after data connect
// (RQ10) FAX code only after fax connect
// (RQ11) Data connect enters online command mode
// (RQ12) Return-online gives connect with line rate
// (RQ13) Carrier detect follows data connection
// (RQ14) Carrier detect rises before DATA code; raised here in the same cycle as the DATA result
// (RQ15) Carrier detect shown at status bit 7
// (RQ16) Host sends carrier-follow command
// (RQ17) Answer tone waits for handshake window
// (RQ18) FAX message at data rate, class 1
// (RQ19) Three seconds tone, then fax flags
// (RQ20) Fax connect reported at 19200 port rate
// (RQ21) Unknown caller: no carrier, on-hook, data
// (RQ22) Answer after programmed number of rings
// (RQ23) Online command mode answers commands with OK
`timescale 1ns/1ps
`include "faa_params.svh"

module data_fax_auto_answer import faa_pkg::*; #(
	parameter int SEC_CYCLES = `FAA_SEC_NS / `FAA_CLK_NS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Host commands
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_code,
	input wire logic [7:0] cmd_arg,
	output logic cmd_ready,
	// Host results
	output logic result_valid,
	output logic [7:0] result_code,
	output logic [15:0] result_rate,
	output logic port_rate_fax,
	// Registers and status
	output logic [7:0] data_handshake_timeout,
	output logic [7:0] ring_count_answer,
	output logic [7:0] modem_status,
	// Nonvolatile store
	input wire logic auto_answer_nv_slot,
	output logic nv_write,
	output logic nv_wdata,
	// Line side events
	input wire logic ring_cycle,
	input wire logic ring_ended,
	input wire logic data_connected,
	input wire logic caller_unknown,
	input wire logic carrier_lost,
	input wire logic [15:0] line_rate,
	// Line side controls
	output logic off_hook,
	output logic answer_tone,
	output logic fax_hdlc_flags,
	output logic fax_service_class,
	output logic carrier_detect
);

	// ---------------------------------------------------------------
	// State and stored settings
	// ---------------------------------------------------------------
	state_e state, next_state;
	logic auto_enable, carrier_follow, cd_conn, nv_loaded;
	logic [7:0] rings;
	logic next_valid;
	logic [7:0] next_code;
	logic [15:0] next_rate;
	logic hs_start, hs_done, tone_start, tone_done;

	wire st_idle = (state == ST_IDLE);
	wire st_ring = (state == ST_RING);
	wire st_hs = (state == ST_HANDSHAKE);
	wire st_online = (state == ST_ONLINE_CMD);
	wire st_data = (state == ST_DATA);
	wire st_tone = (state == ST_FAX_TONE);
	wire st_fax = (state == ST_FAX_TX);

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	// Commands are refused while the line owns the sequence, so a line
	// event and a host command never compete for the one result slot.
	wire line_evt = (st_idle & ring_cycle) | (st_ring & (ring_cycle | ring_ended)) | (st_online & carrier_lost);
	assign cmd_ready = (st_idle | st_ring | st_online) & ~line_evt;
	wire cmd_take = cmd_valid & cmd_ready;
	wire cmd_enable = cmd_take & (cmd_code == CMD_AUTO_ANSWER_ENABLE);
	wire cmd_answer = cmd_take & (cmd_code == CMD_MANUAL_ANSWER);
	wire cmd_online = cmd_take & (cmd_code == CMD_RETURN_ONLINE);
	wire cmd_follow = cmd_take & (cmd_code == CMD_CARRIER_FOLLOW);
	wire cmd_timeout = cmd_take & (cmd_code == CMD_SET_TIMEOUT);
	wire cmd_rings = cmd_take & (cmd_code == CMD_SET_RING_COUNT);
	wire [7:0] rings_now = rings + 8'h01;
	wire ring_auto = (ring_count_answer != 8'h00) & (rings_now >= ring_count_answer);

	// ---------------------------------------------------------------
	// Timers
	// ---------------------------------------------------------------
	sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_hs_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(hs_start),
		.abort(~st_hs),
		.secs(data_handshake_timeout),
		.busy(),
		.done(hs_done)
	);

	sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_tone_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(tone_start),
		.abort(~st_tone),
		.secs(`FAA_TONE_SEC),
		.busy(),
		.done(tone_done)
	);

	// ---------------------------------------------------------------
	// Answer sequence
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_valid = 1'b0;
		next_code = `FAA_RES_OK;
		next_rate = 16'h0000;
		hs_start = 1'b0;
		tone_start = 1'b0;
		case (state)
			ST_IDLE: begin
				if (ring_cycle) begin
					next_valid = 1'b1; // see (RQ7)
					next_code = `FAA_RES_RING;
					if (auto_enable & ring_auto) begin
						next_state = ST_HANDSHAKE; // see (RQ8)
						hs_start = 1'b1;
					end else if (auto_enable) begin
						next_state = ST_RING;
					end
				end else if (cmd_take) begin
					next_valid = 1'b1;
				end
			end
			ST_RING: begin
				if (ring_cycle) begin
					next_valid = 1'b1;
					next_code = `FAA_RES_RING;
					if (ring_auto) begin
						next_state = ST_HANDSHAKE; // see (RQ22)
						hs_start = 1'b1;
					end
				end else if (ring_ended) begin
					next_state = ST_IDLE;
				end else if (cmd_answer) begin
					next_state = ST_HANDSHAKE; // see (RQ7)
					hs_start = 1'b1;
				end else if (cmd_take) begin
					next_valid = 1'b1;
				end
			end
			ST_HANDSHAKE: begin
				// Data wins when it lands in the same cycle as the window end
				if (data_connected) begin
					next_state = ST_ONLINE_CMD; // see (RQ4) (RQ11)
					next_valid = 1'b1;
					next_code = `FAA_RES_DATA; // see (RQ9)
				end else if (caller_unknown) begin
					next_state = ST_IDLE; // see (RQ21)
					next_valid = 1'b1;
					next_code = `FAA_RES_NO_CARRIER;
				end else if (hs_done) begin
					next_state = ST_FAX_TONE; // see (RQ6) (RQ17)
					next_valid = 1'b1;
					next_code = `FAA_RES_FAX; // see (RQ10) (RQ18)
					tone_start = 1'b1;
				end
			end
			ST_ONLINE_CMD: begin
				if (carrier_lost) begin
					next_state = ST_IDLE;
					next_valid = 1'b1;
					next_code = `FAA_RES_NO_CARRIER;
				end else if (cmd_online) begin
					next_state = ST_DATA; // see (RQ12)
					next_valid = 1'b1;
					next_code = `FAA_RES_CONNECT;
					next_rate = line_rate;
				end else if (cmd_take) begin
					next_valid = 1'b1; // see (RQ23)
				end
			end
			ST_DATA, ST_FAX_TONE, ST_FAX_TX: begin
				if (carrier_lost) begin
					next_state = ST_IDLE;
					next_valid = 1'b1;
					next_code = `FAA_RES_NO_CARRIER;
				end else if (st_tone & tone_done) begin
					next_state = ST_FAX_TX; // see (RQ19)
					next_valid = 1'b1;
					next_code = `FAA_RES_CONNECT;
					next_rate = `FAA_FAX_PORT_RATE; // see (RQ20)
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			result_valid <= 1'b0;
			result_code <= `FAA_RES_OK;
			result_rate <= 16'h0000;
		end else begin
			state <= next_state;
			result_valid <= next_valid;
			result_code <= next_code;
			result_rate <= next_rate;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rings <= 8'h00;
		end else if (st_idle | ring_ended) begin
			rings <= ring_cycle ? 8'h01 : 8'h00;
		end else if (st_ring & ring_cycle) begin
			rings <= rings_now;
		end
	end

	// ---------------------------------------------------------------
	// Settings
	// ---------------------------------------------------------------
	// The stored enable is picked up one cycle after reset release,
	// never inside the reset branch, so the reset value stays constant.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			nv_loaded <= 1'b0;
			auto_enable <= 1'b0;
		end else if (!nv_loaded) begin
			nv_loaded <= 1'b1;
			auto_enable <= auto_answer_nv_slot;
		end else if (cmd_enable) begin
			auto_enable <= cmd_arg[0]; // see (RQ1)
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			nv_write <= 1'b0;
			nv_wdata <= 1'b0;
		end else begin
			nv_write <= cmd_enable; // see (RQ1)
			nv_wdata <= cmd_enable ? cmd_arg[0] : nv_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			data_handshake_timeout <= `FAA_TIMEOUT_RESET; // see (RQ5)
			ring_count_answer <= `FAA_RING_COUNT_RESET;
			carrier_follow <= 1'b0;
		end else begin
			data_handshake_timeout <= cmd_timeout ? cmd_arg : data_handshake_timeout;
			ring_count_answer <= cmd_rings ? cmd_arg : ring_count_answer;
			carrier_follow <= cmd_follow ? cmd_arg[0] : carrier_follow;
		end
	end

	// ---------------------------------------------------------------
	// Line controls and status
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cd_conn <= 1'b0;
			fax_service_class <= 1'b1;
		end else begin
			// Raised on the connect edge, in the same cycle as the DATA result
			cd_conn <= (next_state == ST_ONLINE_CMD) | (next_state == ST_DATA); // see (RQ13) (RQ14)
			if (hs_start)
				fax_service_class <= 1'b0;
			else if (st_hs & hs_done & ~data_connected & ~caller_unknown)
				fax_service_class <= 1'b1; // see (RQ6) (RQ18)
		end
	end

	// Without carrier-follow the indicator is held on, as plain modems do
	assign carrier_detect = carrier_follow ? cd_conn : 1'b1; // see (RQ13)
	assign off_hook = st_hs | st_online | st_data | st_tone | st_fax;
	assign answer_tone = st_tone; // see (RQ19)
	assign fax_hdlc_flags = st_fax;
	// The FAX message itself still goes out at the data rate
	assign port_rate_fax = st_fax; // see (RQ18) (RQ20)
	assign modem_status = {carrier_detect, 4'h0, auto_enable, fax_service_class, off_hook}; // see (RQ15)

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [39:0] hs_cnt, tone_cnt;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hs_cnt <= 40'h0;
			tone_cnt <= 40'h0;
		end else begin
			hs_cnt <= st_hs ? hs_cnt + 40'h1 : 40'h0;
			tone_cnt <= st_tone ? tone_cnt + 40'h1 : 40'h0;
		end
	end

	property p_cd_status;
		@(posedge clk_sys) disable iff (reset)
		modem_status[`FAA_CD_BIT] == (carrier_follow ? (st_online | st_data) : 1'b1);
	endproperty
	a_cd_status: assert property (p_cd_status) else $error("status bit 7 differs from connection"); // see (RQ15) (RQ13)

	property p_cd_before_data;
		@(posedge clk_sys) disable iff (reset)
		result_valid && result_code == `FAA_RES_DATA |-> cd_conn && st_online;
	endproperty
	a_cd_before_data: assert property (p_cd_before_data) else $error("DATA reported without carrier"); // see (RQ14)

	property p_fax_class;
		@(posedge clk_sys) disable iff (reset)
		result_valid && result_code == `FAA_RES_FAX |-> fax_service_class && st_tone && !port_rate_fax;
	endproperty
	a_fax_class: assert property (p_fax_class) else $error("FAX without class 1 or tone"); // see (RQ18)

	property p_window;
		@(posedge clk_sys) disable iff (reset)
		st_hs && hs_done && data_handshake_timeout != 8'h00 |->
		longint'(hs_cnt) == longint'(data_handshake_timeout) * SEC_CYCLES - 1;
	endproperty
	a_window: assert property (p_window) else $error("handshake window length wrong"); // see (RQ5)

	property p_tone_len;
		@(posedge clk_sys) disable iff (reset)
		st_tone && tone_done |-> longint'(tone_cnt) == longint'(`FAA_TONE_SEC) * longint'(SEC_CYCLES) - 1;
	endproperty
	a_tone_len: assert property (p_tone_len) else $error("answer tone length wrong"); // see (RQ19)

	property p_fax_connect;
		@(posedge clk_sys) disable iff (reset)
		st_tone && tone_done && !carrier_lost |=> st_fax && result_valid &&
		result_code == `FAA_RES_CONNECT && result_rate == `FAA_FAX_PORT_RATE;
	endproperty
	a_fax_connect: assert property (p_fax_connect) else $error("fax connect rate wrong"); // see (RQ20)

	property p_online;
		@(posedge clk_sys) disable iff (reset)
		st_online && cmd_online |=> st_data && result_valid && result_code == `FAA_RES_CONNECT &&
		result_rate == $past(line_rate);
	endproperty
	a_online: assert property (p_online) else $error("return online not connected"); // see (RQ12)

	property p_online_ok;
		@(posedge clk_sys) disable iff (reset)
		st_online && cmd_take && !cmd_online |=> st_online && result_valid && result_code == `FAA_RES_OK;
	endproperty
	a_online_ok: assert property (p_online_ok) else $error("online command not answered OK"); // see (RQ23)

	property p_unknown;
		@(posedge clk_sys) disable iff (reset)
		st_hs && caller_unknown && !data_connected |=> !off_hook && !fax_service_class &&
		result_code == `FAA_RES_NO_CARRIER;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown caller not dropped"); // see (RQ21)

	property p_manual;
		@(posedge clk_sys) disable iff (reset) st_ring && cmd_answer |=> st_hs && off_hook;
	endproperty
	a_manual: assert property (p_manual) else $error("manual answer did not seize line"); // see (RQ7)

	c_data: cover property (@(posedge clk_sys) disable iff (reset) st_online ##1 st_data);
	c_fax: cover property (@(posedge clk_sys) disable iff (reset) st_tone ##1 st_fax);
	c_unknown: cover property (@(posedge clk_sys) disable iff (reset) st_hs && caller_unknown);
	c_auto_ring: cover property (@(posedge clk_sys) disable iff (reset) st_ring && ring_cycle && ring_auto);

endmodule // data_fax_auto_answer

// File: pkg/faa_params.svh
/*
 Named constants for the data/fax auto-answer controller: reset values,
 result codes, status bit positions and timing figures.
 Assumes a single 20 MHz system clock.
*/
`ifndef FAA_PARAMS_SVH
`define FAA_PARAMS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FAA_CLK_NS 50
`define FAA_SEC_NS 1000000000
`define FAA_TONE_SEC 8'h03

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FAA_TIMEOUT_RESET 8'h06
`define FAA_RING_COUNT_RESET 8'h00

// ---------------------------------------------------------------
// Numeric result codes
// ---------------------------------------------------------------
`define FAA_RES_OK 8'h00
`define FAA_RES_CONNECT 8'h01
`define FAA_RES_RING 8'h02
`define FAA_RES_NO_CARRIER 8'h03
`define FAA_RES_DATA 8'h0D
`define FAA_RES_FAX 8'h0F

// ---------------------------------------------------------------
// Rates and status layout
// ---------------------------------------------------------------
`define FAA_FAX_PORT_RATE 16'h4B00
`define FAA_CD_BIT 7
`define FAA_OFFHOOK_BIT 0
`define FAA_FAXCLASS_BIT 1
`define FAA_AUTO_BIT 2

`endif

// File: pkg/faa_pkg.sv
/*
 Types shared by the auto-answer controller: host command codes and
 the one-hot answer sequence states.
 Assumes faa_params.svh supplies the numeric constants.
*/
package faa_pkg;

	// ---------------------------------------------------------------
	// Host commands
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_AUTO_ANSWER_ENABLE = 4'h1,
		CMD_MANUAL_ANSWER = 4'h2,
		CMD_RETURN_ONLINE = 4'h3,
		CMD_CARRIER_FOLLOW = 4'h4,
		CMD_SET_TIMEOUT = 4'h5,
		CMD_SET_RING_COUNT = 4'h6,
		CMD_OTHER = 4'h7
	} cmd_e;

	// ---------------------------------------------------------------
	// Answer sequence
	// ---------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RING = 7'h02,
		ST_HANDSHAKE = 7'h04,
		ST_ONLINE_CMD = 7'h08,
		ST_DATA = 7'h10,
		ST_FAX_TONE = 7'h20,
		ST_FAX_TX = 7'h40
	} state_e;

endpackage

// File: hdl/sec_timer.sv
/*
 Whole-second down timer used for the handshake window and the answer
 tone. Assumes start is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`include "faa_params.svh"

module sec_timer #(
	parameter int SEC_CYCLES = 20000000
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [7:0] secs,
	// Status
	output logic busy,
	output logic done
);
	localparam int CW = $clog2(SEC_CYCLES + 1);

	logic [CW-1:0] cyc;
	logic [7:0] sec;
	wire sec_end = (cyc == CW'(SEC_CYCLES - 1));

	// Zero seconds ends at once, so a zero window is not a full wrap
	assign done = busy & ((sec == 8'h00) | (sec_end & (sec == 8'h01)));

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			cyc <= '0;
			sec <= 8'h00;
		end else if (start) begin
			busy <= 1'b1;
			cyc <= '0;
			sec <= secs;
		end else if (abort | done) begin
			busy <= 1'b0;
		end else if (busy) begin
			cyc <= sec_end ? '0 : cyc + 1'b1;
			sec <= sec_end ? sec - 8'h01 : sec;
		end
	end

endmodule // sec_timer

// File: dv/host_term_model.sv
/*
 Host terminal model: issues one command at a time on the command port.
 Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ps

module host_term_model import faa_pkg::*; (
	// Clock
	input wire logic clk_sys,
	// Command port
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [3:0] cmd_code,
	output logic [7:0] cmd_arg,
	// Modem state seen by the host
	input wire logic fax_service_class
);
	// ---------------------------------------------------------------
	// Host side state
	// ---------------------------------------------------------------
	int port_rate = 19200;

	initial begin
		cmd_valid = 1'b0;
		cmd_code = 4'h0;
		cmd_arg = 8'h00;
	end

	// Request held unchanged until the edge that takes it
	task automatic send(input cmd_e code, input logic [7:0] arg);
		logic rdy;
		int n;
		@(posedge clk_sys);
		#5;
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_arg = arg;
		rdy = 1'b0;
		n = 0;
		while (rdy !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			rdy = cmd_ready;
			@(posedge clk_sys);
			n++;
		end
		#5;
		cmd_valid = 1'b0;
		// Released lines must not keep looking like a command
		cmd_code = ~code;
		cmd_arg = ~arg;
	endtask

	task automatic follow_carrier();
		send(CMD_CARRIER_FOLLOW, 8'h01);
	endtask

	task automatic enable_auto();
		if (fax_service_class === 1'b1) begin
			send(CMD_AUTO_ANSWER_ENABLE, 8'h01);
			port_rate = 2400;
		end
	endtask
endmodule // host_term_model

// File: dv/data_fax_auto_answer_tb.sv
/*
 Self-checking bench for the auto-answer controller: data, fax and
 unknown callers, with random timeout and line rate.
 Assumes the host model drives commands; the bench drives line events.
*/
`timescale 1ns/1ps
`include "faa_params.svh"

module data_fax_auto_answer_tb import faa_pkg::*;;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int SEC = 10;
	localparam logic [4:0] EV_END = 5'b10000, EV_RING = 5'b01000, EV_DATA = 5'b00100;
	localparam logic [4:0] EV_UNK = 5'b00010, EV_LOST = 5'b00001;
	logic clk_sys = 1'b0, reset = 1'b1;
	logic cmd_valid, cmd_ready, result_valid, port_rate_fax, auto_answer_nv_slot, nv_write, nv_wdata;
	logic [3:0] cmd_code;
	logic [7:0] cmd_arg, result_code, data_handshake_timeout, ring_count_answer, modem_status;
	logic [15:0] result_rate, line_rate, rate;
	logic ring_cycle, ring_ended, data_connected, caller_unknown, carrier_lost;
	logic off_hook, answer_tone, fax_hdlc_flags, fax_service_class, carrier_detect;
	logic [24:0] resq[$];
	logic nv_seen = 1'b0, last_cd;
	logic [7:0] tmo;
	logic [15:0] rates[3] = '{16'h0960, 16'h04B0, 16'h012C};
	int mismatches = 0, compares = 0, cycles = 0, k;
	integer seed = 32'h1BA9;

	always #25 clk_sys = ~clk_sys;

	data_fax_auto_answer #(.SEC_CYCLES(SEC)) i_data_fax_auto_answer (.clk_sys(clk_sys), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
		.result_valid(result_valid), .result_code(result_code), .result_rate(result_rate),
		.port_rate_fax(port_rate_fax), .data_handshake_timeout(data_handshake_timeout),
		.ring_count_answer(ring_count_answer), .modem_status(modem_status),
		.auto_answer_nv_slot(auto_answer_nv_slot), .nv_write(nv_write), .nv_wdata(nv_wdata),
		.ring_cycle(ring_cycle), .ring_ended(ring_ended), .data_connected(data_connected),
		.caller_unknown(caller_unknown), .carrier_lost(carrier_lost), .line_rate(line_rate),
		.off_hook(off_hook), .answer_tone(answer_tone), .fax_hdlc_flags(fax_hdlc_flags),
		.fax_service_class(fax_service_class), .carrier_detect(carrier_detect));

	host_term_model i_host_term_model (.clk_sys(clk_sys), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_arg(cmd_arg), .fax_service_class(fax_service_class));

	// ---------------------------------------------------------------
	// Monitors, checks and expectations
	// ---------------------------------------------------------------
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (result_valid === 1'b1)
			resq.push_back({carrier_detect, result_code, result_rate});
		if (nv_write === 1'b1)
			nv_seen <= nv_wdata;
		if (cycles == 5000) begin
			mismatches++;
			print_verdict();
		end
	end

	function automatic int window_cycles(input logic [7:0] t);
		return (t == 8'h00) ? 1 : t * SEC;
	endfunction

	function automatic logic [7:0] status_exp(input logic cd, auto_on, fc, oh);
		return {cd, 4'h0, auto_on, fc, oh};
	endfunction

	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_flag(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic expect_result(input string what, input logic [7:0] code, input logic [15:0] r);
		logic [24:0] e;
		int n;
		n = 0;
		while (resq.size() == 0 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		e = (resq.size() == 0) ? 25'h1FFFFFF : resq.pop_front();
		last_cd = e[24];
		check_val({what, " code"}, {8'h00, code}, {8'h00, e[23:16]});
		check_val({what, " rate"}, r, e[15:0]);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask

	task automatic line_event(input logic [4:0] ev);
		cyc(1);
		{ring_ended, ring_cycle, data_connected, caller_unknown, carrier_lost} = ev;
		cyc(1);
		{ring_ended, ring_cycle, data_connected, caller_unknown, carrier_lost} = 5'b00000;
	endtask

	task automatic set_reg(input cmd_e c, input logic [7:0] v);
		i_host_term_model.send(c, v);
		expect_result("setting", `FAA_RES_OK, 16'h0000);
	endtask

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		auto_answer_nv_slot = 1'b0;
		{ring_ended, ring_cycle, data_connected, caller_unknown, carrier_lost} = 5'b00000;
		line_rate = 16'h0000;
		repeat (10) @(posedge clk_sys);
		#5;
		reset = 1'b0;
		cyc(2);
		check_val("timeout reset", {8'h00, `FAA_TIMEOUT_RESET}, {8'h00, data_handshake_timeout});
		check_val("ring count reset", {8'h00, `FAA_RING_COUNT_RESET}, {8'h00, ring_count_answer});
		line_event(EV_RING);
		expect_result("ring auto off", `FAA_RES_RING, 16'h0000);
		check_flag("stays on hook", 1'b0, off_hook);
		line_event(EV_END);
		i_host_term_model.follow_carrier();
		expect_result("follow", `FAA_RES_OK, 16'h0000);
		i_host_term_model.enable_auto();
		expect_result("enable", `FAA_RES_OK, 16'h0000);
		check_flag("nv stored", 1'b1, nv_seen);
		check_val("status idle", {8'h00, status_exp(1'b0, 1'b1, 1'b1, 1'b0)}, {8'h00, modem_status});
		$display("test setup done");
		for (k = 0; k < 2; k++) begin
			rate = rates[$unsigned($random(seed)) % 3];
			line_rate = rate;
			line_event(EV_RING);
			expect_result("ring", `FAA_RES_RING, 16'h0000);
			i_host_term_model.send(CMD_MANUAL_ANSWER, 8'h00);
			cyc(1);
			check_flag("manual off hook", 1'b1, off_hook);
			check_flag("busy in handshake", 1'b0, cmd_ready);
			check_flag("cd off before connect", 1'b0, carrier_detect);
			line_event(EV_DATA);
			expect_result("data", `FAA_RES_DATA, 16'h0000);
			check_flag("cd with data code", 1'b1, last_cd);
			check_val("status online", {8'h00, status_exp(1'b1, 1'b1, 1'b0, 1'b1)}, {8'h00, modem_status});
			i_host_term_model.send(CMD_OTHER, 8'($random(seed)));
			expect_result("online cmd", `FAA_RES_OK, 16'h0000);
			i_host_term_model.send(CMD_RETURN_ONLINE, 8'h00);
			expect_result("connect", `FAA_RES_CONNECT, rate);
			line_event(EV_LOST);
			expect_result("lost", `FAA_RES_NO_CARRIER, 16'h0000);
			check_flag("cd off after", 1'b0, carrier_detect);
			check_flag("hung up", 1'b0, off_hook);
		end
		$display("test data call done");
		tmo = 8'(1 + $unsigned($random(seed)) % 3);
		set_reg(CMD_SET_TIMEOUT, tmo);
		check_val("timeout", {8'h00, tmo}, {8'h00, data_handshake_timeout});
		set_reg(CMD_SET_RING_COUNT, 8'h02);
		check_val("ring count", 16'h0002, {8'h00, ring_count_answer});
		line_event(EV_RING);
		expect_result("ring one", `FAA_RES_RING, 16'h0000);
		check_flag("waits for rings", 1'b0, off_hook);
		line_event(EV_RING);
		expect_result("ring two", `FAA_RES_RING, 16'h0000);
		check_flag("auto off hook", 1'b1, off_hook);
		check_flag("data tried first", 1'b0, fax_service_class);
		cyc(window_cycles(tmo) - 3);
		check_flag("tone held back", 1'b0, answer_tone);
		check_val("no early result", 16'h0000, 16'(resq.size()));
		expect_result("fax", `FAA_RES_FAX, 16'h0000);
		check_flag("fax class", 1'b1, fax_service_class);
		check_flag("fax msg at data rate", 1'b0, port_rate_fax);
		cyc(3 * SEC - 4);
		check_flag("tone on", 1'b1, answer_tone);
		check_flag("no flags yet", 1'b0, fax_hdlc_flags);
		expect_result("fax connect", `FAA_RES_CONNECT, `FAA_FAX_PORT_RATE);
		check_flag("flags", 1'b1, fax_hdlc_flags);
		check_flag("fax port rate", 1'b1, port_rate_fax);
		line_event(EV_LOST);
		expect_result("fax lost", `FAA_RES_NO_CARRIER, 16'h0000);
		$display("test fax call done");
		set_reg(CMD_SET_RING_COUNT, 8'h01);
		line_event(EV_RING);
		expect_result("ring unk", `FAA_RES_RING, 16'h0000);
		line_event(EV_UNK);
		expect_result("unknown", `FAA_RES_NO_CARRIER, 16'h0000);
		check_flag("unknown on hook", 1'b0, off_hook);
		check_flag("stays data mode", 1'b0, fax_service_class);
		$display("test unknown caller done");
		print_verdict();
	end
endmodule // data_fax_auto_answer_tb
